// *** hdl/power_up_reset_sequencer.sv ***
// power-up reset sequencer with configuration word on a wishbone port
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_cfg.svh"

module power_up_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned RC_DIV          = `RSEQ_RC_DIV,
    parameter int unsigned PWR_DELAY_TICKS = `RSEQ_PWR_DELAY_TICKS,
    parameter int unsigned BROWN_MIN_CYC   = `RSEQ_BROWN_MIN_CYC,
    parameter int unsigned OSC_START_CYC   = `RSEQ_OSC_START_CYCLES,
    parameter int unsigned GLITCH_CYC      = `RSEQ_GLITCH_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // analog detectors and pins
    input  wire logic        supply_rise_i,
    input  wire logic        brown_out_i,
    input  wire logic        master_clear_n_i,
    input  wire logic        osc_clock_input_i,
    input  wire logic        prog_mode_i,
    // core events
    input  wire logic        wdt_timeout_i,
    input  wire logic        sleep_req_i,
    input  wire logic        interrupt_i,
    // outputs to the core
    output logic             core_reset_o,
    output logic             sleeping_o,
    output logic             wdt_tick_o,
    output logic             wdt_enable_o,
    output osc_mode_e        osc_mode_o
);

    localparam int unsigned RW = $clog2(RC_DIV + 1);
    localparam int unsigned PW = $clog2(PWR_DELAY_TICKS + 1);
    localparam int unsigned BW = $clog2(BROWN_MIN_CYC + 1);
    localparam int unsigned OW = $clog2(OSC_START_CYC + 1);
    localparam int unsigned GW = $clog2(GLITCH_CYC + 1);

    config_word_s cfg_q;
    seq_state_e   state_q;
    seq_state_e   state_d;
    logic [RW-1:0] rc_cnt_q;
    logic         rc_tick_q;
    logic         rise_q;
    logic         osc_q;
    logic         master_clear_n_filt_q;
    logic         por_seq_q;
    logic         por_flag_q;
    logic         brown_flag_q;
    logic         wdt_flag_q;
    logic         por_pulse;
    logic         osc_rise;
    logic         brown_en;
    logic         pwr_on;
    logic         crystal;
    logic         brown_trip;
    logic         pwr_done;
    logic         osc_done;
    logic         glitch_done;
    logic         wdt_reset;
    logic         bus_req;
    logic         wr_cfg;
    logic         wr_stat;
    status_word_s status;

    // level decode of the configuration word, input edge detects, watchdog reset and bus requests
    assign brown_en  = !cfg_q.brown_out_enable_bit ? 1'b0 : 1'b1;
    assign pwr_on    = !cfg_q.pwr_timer_en_n || brown_en;
    assign crystal   = cfg_q.osc_mode != rc_osc_mode;
    assign por_pulse = supply_rise_i && !rise_q;
    assign osc_rise  = osc_clock_input_i && !osc_q;
    assign wdt_reset = state_q == st_run && wdt_timeout_i;
    assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_cfg    = bus_req && wb_we_i && wb_adr_i == `RSEQ_ADR_CONFIG;
    assign wr_stat   = bus_req && wb_we_i && wb_adr_i == `RSEQ_ADR_STATUS;

    // rc oscillator tick, divided down from the main clock
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rc_cnt_q  <= '0;
            rc_tick_q <= 1'b0;
        end
        else
        begin
            rc_tick_q <= rc_cnt_q == RW'(RC_DIV - 1);
            rc_cnt_q  <= (rc_cnt_q == RW'(RC_DIV - 1)) ? '0 : rc_cnt_q + RW'(1);
        end
    end

    // edge history of detector and oscillator inputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rise_q <= 1'b0;
            osc_q  <= 1'b0;
        end
        else
        begin
            rise_q <= supply_rise_i;
            osc_q  <= osc_clock_input_i;
        end
    end

    // master-clear filter: the pin must differ for the whole window;
    // restarted on the flip itself, else the held done would flip it back
    timeout_counter #(.W(GW)) glitch_cnt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i ((master_clear_n_i == master_clear_n_filt_q) || glitch_done),
        .tick_i  (1'b1),
        .limit_i (GW'(GLITCH_CYC)),
        .done_o  (glitch_done)
    );

    // filtered level flips only after a sustained change
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            master_clear_n_filt_q <= 1'b1;
        else if (glitch_done)
            master_clear_n_filt_q <= ~master_clear_n_filt_q;
    end

    // brown-out trip once the supply stays low for the minimum time
    timeout_counter #(.W(BW)) brown_cnt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (!brown_out_i || !brown_en),
        .tick_i  (1'b1),
        .limit_i (BW'(BROWN_MIN_CYC)),
        .done_o  (brown_trip)
    );

    // power-up delay in rc ticks, restarted whenever the state is left
    timeout_counter #(.W(PW)) pwr_cnt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (state_q != st_pwr_delay),
        .tick_i  (rc_tick_q),
        .limit_i (PW'(PWR_DELAY_TICKS)),
        .done_o  (pwr_done)
    );

    // oscillator start-up count on rising edges of the oscillator input
    timeout_counter #(.W(OW)) osc_cnt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (state_q != st_osc_wait),
        .tick_i  (osc_rise),
        .limit_i (OW'(OSC_START_CYC)),
        .done_o  (osc_done)
    );

    // next state; power-on first, then brown-out, then the normal walk
    always_comb
    begin
        state_d = state_q;
        if (por_pulse)
            state_d = st_pwr_delay;
        else if (brown_trip || (state_q == st_pwr_delay && brown_en && brown_out_i))
            state_d = st_brown_hold;
        else
        begin
            unique case (state_q)
                st_brown_hold:
                    if (!brown_out_i || !brown_en)
                        state_d = st_pwr_delay;
                st_pwr_delay:
                    if (!pwr_on || pwr_done)
                        state_d = (por_seq_q && crystal) ? st_osc_wait : st_ready;
                st_osc_wait:
                    if (osc_done)
                        state_d = st_ready;
                st_ready:
                    if (master_clear_n_filt_q)
                        state_d = st_run;
                st_run:
                    if (!master_clear_n_filt_q || wdt_timeout_i)
                        state_d = st_ready;
                    else if (sleep_req_i)
                        state_d = st_sleep;
                st_sleep:
                    if (!master_clear_n_filt_q)
                        state_d = st_ready;
                    else if (wdt_timeout_i || interrupt_i)
                        state_d = crystal ? st_osc_wait : st_run;
                default:
                    state_d = st_brown_hold;
            endcase
        end
    end

    // state register; a brown-out path never runs the start-up count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q   <= st_brown_hold;
            por_seq_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            if (por_pulse)
                por_seq_q <= 1'b1;
            else if (state_d == st_brown_hold)
                por_seq_q <= 1'b0;
        end
    end

    // core-facing outputs straight from flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_reset_o <= 1'b1;
            sleeping_o   <= 1'b0;
            wdt_tick_o   <= 1'b0;
            wdt_enable_o <= 1'b0;
            osc_mode_o   <= rc_osc_mode;
        end
        else
        begin
            core_reset_o <= state_d != st_run;
            sleeping_o   <= state_d == st_sleep;
            wdt_tick_o   <= rc_tick_q && cfg_q.watchdog_en;
            wdt_enable_o <= cfg_q.watchdog_en;
            osc_mode_o   <= cfg_q.osc_mode;
        end
    end

    // configuration word, only open to writes while programming
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_q <= config_word_s'(`RSEQ_CONFIG_RESET);
        else if (wr_cfg && prog_mode_i)
        begin
            if (wb_sel_i[0])
                cfg_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                cfg_q[13:8] <= wb_dat_i[13:8];
        end
    end

    // sticky reset causes; a new event wins over a write-one clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            por_flag_q   <= 1'b0;
            brown_flag_q <= 1'b0;
            wdt_flag_q   <= 1'b0;
        end
        else
        begin
            por_flag_q   <= por_pulse ||
                            (por_flag_q && !(wr_stat && wb_sel_i[0] && wb_dat_i[5]));
            brown_flag_q <= brown_trip ||
                            (brown_flag_q && !(wr_stat && wb_sel_i[0] && wb_dat_i[6]));
            wdt_flag_q   <= wdt_reset ||
                            (wdt_flag_q && !(wr_stat && wb_sel_i[0] && wb_dat_i[7]));
        end
    end

    // status view of the sequencer
    always_comb
    begin
        status                    = '0;
        status.wdt_flag           = wdt_flag_q;
        status.brown_flag         = brown_flag_q;
        status.por_flag           = por_flag_q;
        status.brown_level        = brown_out_i;
        status.master_clear_level = master_clear_n_filt_q;
        status.state              = state_q;
    end

    // wishbone answer one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && wb_adr_i == `RSEQ_ADR_CONFIG && prog_mode_i)
                wb_dat_o <= {18'h0_0000, cfg_q};
            else if (bus_req && wb_adr_i == `RSEQ_ADR_STATUS)
                wb_dat_o <= status;
            else if (bus_req)
                wb_dat_o <= '0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    power_on_entry_a: assert property (por_pulse |=> state_q == st_pwr_delay)
        else $error("power-on pulse did not start the power-up delay");

    pwr_hold_a: assert property (state_q == st_pwr_delay |=> core_reset_o)
        else $error("reset released during the power-up delay");

    forced_timer_a: assert property (
        (state_q == st_pwr_delay && brown_en && !pwr_done && !por_pulse && !brown_out_i
         && !brown_trip) |=> state_q == st_pwr_delay)
        else $error("power-up delay skipped with brown-out enabled");

    osc_after_pwr_a: assert property (
        (state_q == st_pwr_delay && state_d == st_osc_wait) |-> (pwr_done || !pwr_on))
        else $error("start-up count began before the power-up delay ended");

    osc_mode_only_a: assert property (state_q == st_osc_wait |-> crystal)
        else $error("start-up count run in rc mode");

    glitch_ignored_a: assert property (
        master_clear_n_filt_q && master_clear_n_i ##1 !master_clear_n_i ##1 master_clear_n_i
        |-> master_clear_n_filt_q)
        else $error("one-cycle master-clear glitch changed the filtered level");

    brown_restart_a: assert property (
        (state_q == st_pwr_delay && brown_en && brown_out_i && !por_pulse)
        |=> state_q == st_brown_hold ##1 core_reset_o)
        else $error("brown-out during power-up delay did not restart");

    brown_trip_len_a: assert property (
        $rose(brown_trip) |-> $past(brown_out_i) && brown_en)
        else $error("brown-out tripped without a low supply");

    wdt_internal_a: assert property (
        (wdt_reset && !por_pulse && !brown_trip) |=> state_q == st_ready && wdt_flag_q)
        else $error("watchdog reset not taken internally");

    config_locked_a: assert property (!prog_mode_i |=> $stable(cfg_q))
        else $error("configuration word changed outside programming");

    sleep_exit_a: assert property (
        (state_q == st_sleep && interrupt_i && !por_pulse && !brown_trip)
        |=> state_q != st_sleep ##1 !sleeping_o)
        else $error("interrupt did not end sleep");

    release_cause_a: assert property ($fell(core_reset_o) |-> state_q == st_run)
        else $error("reset released outside the run state");

    wdt_gate_a: assert property (wdt_tick_o |-> $past(cfg_q.watchdog_en))
        else $error("watchdog tick with watchdog disabled");

endmodule

`default_nettype wire

// *** hdl/reset_seq_cfg.svh ***
// offsets, reset values and timing counts of the power-up reset sequencer
`ifndef RESET_SEQ_CFG_SVH
`define RESET_SEQ_CFG_SVH

// register byte addresses on the wishbone port
`define RSEQ_ADR_CONFIG   8'h00
`define RSEQ_ADR_STATUS   8'h04
`define RSEQ_ADR_WIDTH    8

// configuration word: unprogrammed bits read as one
`define RSEQ_CONFIG_RESET 14'h3FFF

// main clock and internal rc oscillator periods
`define RSEQ_CLK_PERIOD_NS 10
`define RSEQ_RC_PERIOD_NS  1000
`define RSEQ_RC_DIV        (`RSEQ_RC_PERIOD_NS / `RSEQ_CLK_PERIOD_NS)

// power-up delay, counted in rc oscillator ticks (least time, rounded up)
`define RSEQ_PWR_DELAY_MS    72
`define RSEQ_PWR_DELAY_TICKS \
    ((`RSEQ_PWR_DELAY_MS * 1000000 + `RSEQ_RC_PERIOD_NS - 1) / `RSEQ_RC_PERIOD_NS)

// brown-out minimum duration in main clock cycles
`define RSEQ_BROWN_MIN_US  100
`define RSEQ_BROWN_MIN_CYC \
    ((`RSEQ_BROWN_MIN_US * 1000 + `RSEQ_CLK_PERIOD_NS - 1) / `RSEQ_CLK_PERIOD_NS)

// oscillator start-up length in oscillator input cycles
`define RSEQ_OSC_START_CYCLES 1024

// master-clear glitch filter: a level must stand this long to count
`define RSEQ_GLITCH_NS  100
`define RSEQ_GLITCH_CYC \
    ((`RSEQ_GLITCH_NS + `RSEQ_CLK_PERIOD_NS - 1) / `RSEQ_CLK_PERIOD_NS)

`endif

// *** hdl/reset_seq_pkg.sv ***
// types shared by the power-up reset sequencer
package reset_seq_pkg;

    // oscillator selection field of the configuration word
    typedef enum logic [1:0] {
        low_power_crystal_mode = 2'h0,
        standard_crystal_mode  = 2'h1,
        high_speed_crystal_mode = 2'h2,
        rc_osc_mode            = 2'h3
    } osc_mode_e;

    // reset sequence states
    typedef enum logic [2:0] {
        st_brown_hold = 3'h0,
        st_pwr_delay  = 3'h1,
        st_osc_wait   = 3'h2,
        st_ready      = 3'h3,
        st_run        = 3'h4,
        st_sleep      = 3'h5
    } seq_state_e;

    // configuration word, 14 bits, a programmed bit reads zero
    typedef struct packed {
        logic [8:0] spare;
        logic       brown_out_enable_bit;
        logic       pwr_timer_en_n;
        logic       watchdog_en;
        osc_mode_e  osc_mode;
    } config_word_s;

    // status word, low byte carries state and sticky reset causes
    typedef struct packed {
        logic [23:0] zero;
        logic        wdt_flag;
        logic        brown_flag;
        logic        por_flag;
        logic        brown_level;
        logic        master_clear_level;
        seq_state_e  state;
    } status_word_s;

endpackage

// *** hdl/timeout_counter.sv ***
// event counter that raises a done level after a given number of ticks
`timescale 1ns/1ps
`default_nettype none

module timeout_counter #(
    parameter int unsigned W = 16
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // control
    input  wire logic         clear_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] limit_i,
    // result
    output logic              done_o
);

    logic [W-1:0] count_q;

    // counting stops at the limit so done stays up until cleared
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_i)
        begin
            count_q <= '0;
            done_o  <= 1'b0;
        end
        else if (tick_i && !done_o)
        begin
            count_q <= count_q + W'(1);
            done_o  <= (count_q + W'(1)) >= limit_i;
        end
    end

endmodule

`default_nettype wire

// *** verification/far_side_model.sv ***
// far-side model: supply detectors, master-clear pin and crystal oscillator
`timescale 1ns/1ps
`default_nettype none

module far_side_model (
    // clock
    input  wire logic clk_i,
    // pins toward the sequencer
    output logic      supply_rise_o,
    output logic      brown_out_o,
    output logic      master_clear_n_o,
    output logic      osc_clock_o
);
    logic [1:0] osc_div_q;
    logic       powered_q;

    // supply starts below the brown-out threshold, pin pulled high
    initial
    begin
        supply_rise_o    = 1'b0;
        brown_out_o      = 1'b1;
        master_clear_n_o = 1'b1;
        osc_clock_o      = 1'b0;
        osc_div_q        = 2'h0;
        powered_q        = 1'b0;
    end

    // crystal swings only once powered; one rise every six clocks
    always @(posedge clk_i)
    begin
        if (powered_q)
        begin
            osc_div_q <= (osc_div_q == 2'h2) ? 2'h0 : osc_div_q + 2'h1;
            if (osc_div_q == 2'h2)
                osc_clock_o <= ~osc_clock_o;
        end
    end

    // supply climbs through the detector window
    task automatic supply_up();
    begin
        @(posedge clk_i);
        supply_rise_o <= 1'b1;
        brown_out_o   <= 1'b0;
        powered_q     <= 1'b1;
    end
    endtask

    // comparator level, changed on a clock edge
    task automatic set_brown(input logic v);
    begin
        @(posedge clk_i);
        brown_out_o <= v;
    end
    endtask

    // external reset pin level
    task automatic set_clear(input logic v);
    begin
        @(posedge clk_i);
        master_clear_n_o <= v;
    end
    endtask
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench of the power-up reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_cfg.svh"

module tb_top
    import reset_seq_pkg::*;
();
    localparam int RCD = 2;
    localparam int PWR = 5;
    localparam int BMIN = 8;
    localparam int OSCN = 4;
    localparam int GL = `RSEQ_GLITCH_CYC;
    typedef struct packed {logic [31:0] v; logic [31:0] m;} note_s;

    logic        clk, rst, cyc, stb, we, ack, prog, wdt_to, slp_req, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r;
    logic        sup, brn, master_clear_n_n, osc, core_rst, sleeping, tick, wdt_en;
    osc_mode_e   mode;
    note_s       notes[$];
    note_s       cur;
    int          fails, checks_done, n, k, r;
    logic        any;

    power_up_reset_sequencer #(.RC_DIV(RCD), .PWR_DELAY_TICKS(PWR), .BROWN_MIN_CYC(BMIN),
        .OSC_START_CYC(OSCN)) dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .supply_rise_i(sup), .brown_out_i(brn),
        .master_clear_n_i(master_clear_n_n), .osc_clock_input_i(osc), .prog_mode_i(prog),
        .wdt_timeout_i(wdt_to), .sleep_req_i(slp_req), .interrupt_i(irq),
        .core_reset_o(core_rst), .sleeping_o(sleeping), .wdt_tick_o(tick),
        .wdt_enable_o(wdt_en), .osc_mode_o(mode));

    far_side_model model (.clk_i(clk), .supply_rise_o(sup), .brown_out_o(brn),
        .master_clear_n_o(master_clear_n_n), .osc_clock_o(osc));

    always #5 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    // one classic cycle; for reads d is the expected value under mask m
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m);
    begin
        @(posedge clk);
        if (!w)
            notes.push_back('{d, m});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= w ? d : 32'h0000_0000;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    end
    endtask

    // read data is judged at the ack edge against the oldest note
    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0)
        begin
            cur = notes.pop_front();
            check(dat_r & cur.m, cur.v);
        end
    end

    // clocks until the core reset reaches a level, bounded
    task automatic wait_rst(input logic lvl, output int c);
    begin
        c = 0;
        @(posedge clk);
        while (core_rst !== lvl && c < 400)
        begin
            @(posedge clk);
            c++;
        end
    end
    endtask

    // was the core reset high at any edge of a window
    task automatic seen_rst(input int c, output logic a);
    begin
        a = 1'b0;
        repeat (c)
        begin
            @(posedge clk);
            a = a | (core_rst === 1'b1);
        end
    end
    endtask

    task automatic print_verdict();
    begin
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // hang guard: whole run is well under this
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end

    initial
    begin
        {clk, cyc, stb, we, prog, wdt_to, slp_req, irq} = '0;
        adr = 8'h00;
        sel = 4'h3;
        dat_w = 32'h0000_0000;
        rst = 1'b1;
        fails = 0;
        checks_done = 0;
        r = $urandom(32'hc9a36034);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wb(0, 8'h00, 32'h0000_0000, 32'hFFFF_FFFF);
        wb(0, 8'h08, 32'h0000_0000, 32'hFFFF_FFFF);
        prog <= 1'b1;
        wb(0, 8'h00, 32'h0000_3FFF, 32'hFFFF_FFFF);
        // every oscillator mode, brown-out kept on so the core stays held
        for (k = 3; k >= 0; k--)
        begin
            wb(1, 8'h00, 32'h0000_3FF4 | k, 32'h0);
            repeat (2) @(posedge clk);
            check(32'(mode), 32'(k));
        end
        // lane 0 alone leaves bits 13:8 as they were; upper lanes random
        sel <= 4'h1 | (4'($urandom) & 4'hC);
        wb(1, 8'h00, 32'h0000_0015, 32'h0);
        wb(0, 8'h00, 32'h0000_3F15, 32'hFFFF_FFFF);
        sel <= 4'h3 | (4'($urandom) & 4'hC);
        // end on the standard crystal, timer and brown-out enabled
        wb(1, 8'h00, 32'h0000_3FF5, 32'h0);
        wb(0, 8'h00, 32'h0000_3FF5, 32'hFFFF_FFFF);
        check(32'(wdt_en), 32'h1);
        prog <= 1'b0;
        check(32'(core_rst), 32'h1);
        // power-on path: rc delay then oscillator count
        model.supply_up();
        wait_rst(1'b0, n);
        check(32'(n >= PWR * RCD + (OSCN - 1) * 6 && n < 400), 32'h1);
        wb(0, 8'h04, 32'h0000_006C, 32'h0000_00FF);
        wb(1, 8'h04, 32'h0000_00E0, 32'h0);
        wb(0, 8'h04, 32'h0000_000C, 32'h0000_00FF);
        k = 0;
        repeat (40)
        begin
            @(posedge clk);
            k += (tick === 1'b1);
        end
        check(k, 40 / RCD);
        // master-clear glitch shorter than the filter
        r = $urandom_range(GL - 1, 1);
        model.set_clear(1'b0);
        repeat (r - 1) @(posedge clk);
        model.set_clear(1'b1);
        seen_rst(12, any);
        check(32'(any), 32'h0);
        model.set_clear(1'b0);
        repeat (20) @(posedge clk);
        check(32'(core_rst), 32'h1);
        model.set_clear(1'b1);
        wait_rst(1'b0, n);
        check(32'(n <= GL + 4), 32'h1);
        // timer disabled but brown-out enabled, rc mode, watchdog off
        prog <= 1'b1;
        wb(1, 8'h00, 32'h0000_3FFB, 32'h0);
        prog <= 1'b0;
        @(posedge clk);
        check(32'(wdt_en), 32'h0);
        r = $urandom_range(BMIN - 2, 1);
        model.set_brown(1'b1);
        repeat (r - 1) @(posedge clk);
        model.set_brown(1'b0);
        seen_rst(16, any);
        check(32'(any), 32'h0);
        model.set_brown(1'b1);
        repeat (20) @(posedge clk);
        check(32'(core_rst), 32'h1);
        wb(0, 8'h04, 32'h0000_0058, 32'h0000_00FF);
        model.set_brown(1'b0);
        repeat (4) @(posedge clk);
        check(32'(core_rst), 32'h1);
        model.set_brown(1'b1);
        repeat (12) @(posedge clk);
        model.set_brown(1'b0);
        wait_rst(1'b0, n);
        check(32'(n >= PWR * RCD && n < 400), 32'h1);
        // watchdog reset stays internal
        @(posedge clk);
        wdt_to <= 1'b1;
        @(posedge clk);
        wdt_to <= 1'b0;
        seen_rst(4, any);
        check(32'(any), 32'h1);
        wb(0, 8'h04, 32'h0000_00CC, 32'h0000_00FF);
        // sleep left by interrupt, then by the external pin
        for (k = 0; k < 2; k++)
        begin
            @(posedge clk);
            slp_req <= 1'b1;
            @(posedge clk);
            slp_req <= 1'b0;
            repeat (2) @(posedge clk);
            check(32'(sleeping), 32'h1);
            if (k == 0)
                irq <= 1'b1;
            else
                model.set_clear(1'b0);
            n = 0;
            while (sleeping !== 1'b0 && n < 20)
            begin
                @(posedge clk);
                n++;
            end
            irq <= 1'b0;
            check(32'(sleeping), 32'h0);
            model.set_clear(1'b1);
            wait_rst(1'b0, n);
        end
        repeat (4) @(posedge clk);
        print_verdict();
    end
endmodule

`default_nettype wire
